// ---- rcg_params.svh ----
// Behaviour
// RQ1 - System reset asserts on power-on, watchdog, lock-up, software request or pad.
// RQ2 - Internal reset sources pull the external reset pad low.
// RQ3 - Internal sources hold system reset at least 20 us.
// RQ4 - External pad held low produces system reset while low.
// RQ5 - System reset spares debug, key, RTC, power and retained clock control.
// RQ6 - Power-on reset clears everything; shutdown exit acts as power-on.
// RQ7 - Power-on reset holds while supply or regulator is not good.
// RQ8 - Lock-up reset request is ignored while a debugger is connected.
// RQ9 - Setting the reset request bit causes a system reset.
// RQ10 - Deep-stop exit resets only the switched core domain.
// RQ11 - System clock source: internal RC, PLL or external oscillator.
// RQ12 - Slow clock from one of: slow RC, slow osc, sysclk/2048, PMU clock.
// RQ13 - After reset the system clock is the fast source divided to 16 MHz.
// RQ14 - Software picks only legal system clock frequencies for active peripherals.
// RQ15 - Software keeps system clock at or above radio bus clock.
// RQ16 - Timer kernel clock runs at the highest reachable fast rate.
// RQ17 - Fixed 16 and 32 MHz references ignore system clock changes.
// RQ18 - Serial ports, random generator and flash get the fixed 16 MHz reference.
// RQ19 - SPI audio mode uses fixed 16/32 MHz, other modes the system clock.
// RQ20 - Public-key accelerator gets half the system clock rate.
// RQ21 - Radio bus clock is system clock divided by 1, 2 or 4.
// RQ22 - Converter clock is 16 MHz from 64 MHz; regulator clock divides it by 2/4.
// RQ23 - Divider changes take effect only at period boundaries, glitch free.
`ifndef RCG_PARAMS_SVH
`define RCG_PARAMS_SVH

`define RCG_CLK_PERIOD_NS   8
`define RCG_RST_MIN_NS      20000
`define RCG_RST_MIN_CYC     ((`RCG_RST_MIN_NS + `RCG_CLK_PERIOD_NS - 1) / `RCG_CLK_PERIOD_NS)
`define RCG_PAD_BLANK_CYC   4
`define RCG_CNT_W           12
`define RCG_DIV_W           11
`define RCG_SYSFREQ_MAX     3'h6
`define RCG_SYS_DIV_RESET   11'h004
`define RCG_REF16_DIV       11'h004
`define RCG_REF32_DIV       11'h002
`define RCG_SLOW_HALF_DIV   11'h400
`define RCG_SYNC_W          7
`define RCG_SYNC_POR        0
`define RCG_SYNC_SUPPLY     1
`define RCG_SYNC_REG        2
`define RCG_SYNC_PAD        3
`define RCG_SYNC_SLOW_RC    4
`define RCG_SYNC_SLOW_OSC   5
`define RCG_SYNC_PMU        6

`endif

// ---- rcg_pkg.sv ----
package rcg_pkg;

    typedef enum logic [1:0] {RCG_SRC_RC, RCG_SRC_PLL, RCG_SRC_EXT} rcg_fast_src_type;

    typedef enum logic [1:0] {RCG_SLOW_RC, RCG_SLOW_OSC, RCG_SLOW_SYSDIV, RCG_SLOW_PMU}
        rcg_slow_src_type;

    typedef enum logic [1:0] {RCG_RDIV1, RCG_RDIV2, RCG_RDIV4} rcg_radio_div_type;

    typedef enum logic [1:0] {RCG_RST_IDLE, RCG_RST_STRETCH, RCG_RST_BLANK} rcg_rst_state_type;

endpackage

// ---- rcg_clock_div.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rcg_params.svh"

module rcg_clock_div
#(
    parameter logic [`RCG_DIV_W-1:0] RESET_DIV = 11'h001
)
(
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  tick_in,
    input  wire logic [`RCG_DIV_W-1:0] divisor,
    output var  logic                  tick_out
);

    logic [`RCG_DIV_W-1:0] count;
    logic [`RCG_DIV_W-1:0] applied;
    logic [`RCG_DIV_W-1:0] next_count;
    logic [`RCG_DIV_W-1:0] next_applied;
    logic                  next_tick_out;

    always_comb
    begin
        next_count    = count;
        next_applied  = applied;
        next_tick_out = 1'b0;
        if (tick_in)
        begin
            if (count >= applied - 11'h001)
            begin
                // New ratio only at the boundary, so no short period escapes
                next_count    = '0;
                next_tick_out = 1'b1;
                next_applied  = (divisor == '0) ? 11'h001 : divisor; // RQ23
            end
            else
            begin
                next_count = count + 11'h001;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            count    <= '0;
            applied  <= RESET_DIV;
            tick_out <= 1'b0;
        end
        else
        begin
            count    <= next_count;
            applied  <= next_applied;
            tick_out <= next_tick_out;
        end
    end

endmodule

`default_nettype wire

// ---- rcg_reset_clock.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rcg_params.svh"

// Clocks are produced as one-cycle enables on core_clk, which stands for
// the fast root, 64 MHz or 32 MHz from the external oscillator; slow clock is a level.
module rcg_reset_clock
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       power_on_reset_n,
    input  wire logic       supply_ok,
    input  wire logic       regulator_ok,
    input  wire logic       shutdown_exit,
    input  wire logic       watchdog_reset,
    input  wire logic       core_a,
    input  wire logic       debugger_connected,
    input  wire logic       reset_request_bit,
    input  wire logic       deepstop_exit,
    input  wire logic       external_reset_pad_n_in,
    output var  logic       external_reset_pad_n_out,
    output var  logic       external_reset_pad_n_oe,
    output var  logic       system_reset_n,
    output var  logic       por_reset_n,
    output var  logic       retained_reset_n,
    output var  logic       switched_core_reset_n,
    input  wire logic [1:0] fast_source_sel,
    input  wire logic [2:0] sys_freq_sel,
    input  wire logic [1:0] slow_source_sel,
    input  wire logic [1:0] radio_clock_divider_sel,
    input  wire logic       regulator_div4,
    input  wire logic       spi_audio_mode,
    input  wire logic       spi_audio_ref32,
    input  wire logic       internal_slow_rc,
    input  wire logic       external_slow_osc,
    input  wire logic       pmu_slow_clock,
    output var  logic [1:0] fast_source_active,
    output var  logic       system_clock_en,
    output var  logic       timer_kernel_en,
    output var  logic       ref16_clock_en,
    output var  logic       ref32_clock_en,
    output var  logic       spi_bit_clock_en,
    output var  logic       pka_clock_en,
    output var  logic       radio_bus_clock_en,
    output var  logic       converter_clock_en,
    output var  logic       regulator_clock_en,
    output var  logic       slow_clock
);

    // Pin synchronisers
    logic [`RCG_SYNC_W-1:0] sync_in;
    logic [`RCG_SYNC_W-1:0] sync_meta;
    logic [`RCG_SYNC_W-1:0] sync_out;

    assign sync_in = {pmu_slow_clock, external_slow_osc, internal_slow_rc,
                      external_reset_pad_n_in, regulator_ok, supply_ok, power_on_reset_n};

    genvar gi;
    generate
        for (gi = 0; gi < `RCG_SYNC_W; gi++)
        begin : g_sync
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    sync_meta[gi] <= 1'b0;
                    sync_out[gi]  <= 1'b0;
                end
                else
                begin
                    sync_meta[gi] <= sync_in[gi];
                    sync_out[gi]  <= sync_meta[gi];
                end
            end
        end
    endgenerate

    // Reset combiner
    logic                         por_active;
    logic                         core_a_req;
    logic                         internal_req;
    logic                         pad_low_ext;
    rcg_pkg::rcg_rst_state_type   rst_state;
    rcg_pkg::rcg_rst_state_type   next_rst_state;
    logic [`RCG_CNT_W-1:0]        rst_cnt;
    logic [`RCG_CNT_W-1:0]        next_rst_cnt;
    logic                         next_system_reset_n;
    logic                         next_pad_oe;
    logic                         next_por_reset_n;
    logic                         next_switched_n;

    assign por_active = !sync_out[`RCG_SYNC_POR] || !sync_out[`RCG_SYNC_SUPPLY]
                        || !sync_out[`RCG_SYNC_REG] || shutdown_exit; // RQ6 RQ7
    assign core_a_req = core_a && !debugger_connected; // RQ8
    assign internal_req = por_active || watchdog_reset || core_a_req
                          || reset_request_bit; // RQ1 RQ9
    // Our own drive is read back through the synchroniser, so the pad is
    // only trusted as an outside request while idle
    assign pad_low_ext = (rst_state == rcg_pkg::RCG_RST_IDLE)
                         && !sync_out[`RCG_SYNC_PAD];

    always_comb
    begin
        next_rst_state = rst_state;
        next_rst_cnt   = rst_cnt;
        unique case (rst_state)
            rcg_pkg::RCG_RST_IDLE:
            begin
                if (internal_req)
                begin
                    next_rst_state = rcg_pkg::RCG_RST_STRETCH;
                    next_rst_cnt   = '0;
                end
            end
            rcg_pkg::RCG_RST_STRETCH:
            begin
                if (rst_cnt < `RCG_CNT_W'(`RCG_RST_MIN_CYC - 1))
                begin
                    next_rst_cnt = rst_cnt + 12'h001; // RQ3
                end
                else if (!internal_req)
                begin
                    next_rst_state = rcg_pkg::RCG_RST_BLANK;
                    next_rst_cnt   = '0;
                end
            end
            rcg_pkg::RCG_RST_BLANK:
            begin
                // A request in the tail restarts the stretch, so reset never blips high
                if (internal_req)
                begin
                    next_rst_state = rcg_pkg::RCG_RST_STRETCH; // RQ1
                    next_rst_cnt   = '0;
                end
                else if (rst_cnt < `RCG_CNT_W'(`RCG_PAD_BLANK_CYC - 1))
                begin
                    next_rst_cnt = rst_cnt + 12'h001;
                end
                else
                begin
                    next_rst_state = rcg_pkg::RCG_RST_IDLE;
                end
            end
            default:
            begin
                next_rst_state = rcg_pkg::RCG_RST_IDLE;
                next_rst_cnt   = '0;
            end
        endcase
        next_pad_oe         = (next_rst_state == rcg_pkg::RCG_RST_STRETCH); // RQ2
        next_system_reset_n = (next_rst_state == rcg_pkg::RCG_RST_IDLE)
                              && !pad_low_ext; // RQ1 RQ4
        next_por_reset_n    = !por_active; // RQ6
        // System reset covers the switched domain too; deep-stop exit hits only it
        next_switched_n     = next_system_reset_n && !deepstop_exit; // RQ10
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rst_state                <= rcg_pkg::RCG_RST_IDLE;
            rst_cnt                  <= '0;
            system_reset_n           <= 1'b0;
            external_reset_pad_n_oe  <= 1'b0;
            external_reset_pad_n_out <= 1'b0;
            por_reset_n              <= 1'b0;
            retained_reset_n         <= 1'b0;
            switched_core_reset_n    <= 1'b0;
        end
        else
        begin
            rst_state                <= next_rst_state;
            rst_cnt                  <= next_rst_cnt;
            system_reset_n           <= next_system_reset_n;
            external_reset_pad_n_oe  <= next_pad_oe;
            external_reset_pad_n_out <= 1'b0;
            por_reset_n              <= next_por_reset_n;
            // Debug, keys, RTC, power and retained clock state see power-on only
            retained_reset_n         <= next_por_reset_n; // RQ5
            switched_core_reset_n    <= next_switched_n;
        end
    end

    // Clock ratios
    logic                    src_ext;
    logic [2:0]              freq_code;
    logic [`RCG_DIV_W-1:0]   sys_div;
    logic [`RCG_DIV_W-1:0]   ref16_div;
    logic [`RCG_DIV_W-1:0]   ref32_div;
    logic [`RCG_DIV_W-1:0]   radio_div;
    logic [`RCG_DIV_W-1:0]   reg_div;
    logic                    slow_half_tick;
    logic                    slow_sys_level;
    logic                    next_slow_sys_level;
    logic                    next_slow_clock;
    logic                    next_spi_en;
    logic [1:0]              next_src_active;

    assign src_ext = (fast_source_sel == rcg_pkg::RCG_SRC_EXT);
    assign freq_code = (sys_freq_sel > `RCG_SYSFREQ_MAX) ? `RCG_SYSFREQ_MAX : sys_freq_sel;

    always_comb
    begin
        // External oscillator is a 32 MHz root, so the system and reference ratios halve, except a /1 system ratio
        sys_div = 11'h001 << freq_code;
        if (src_ext && (freq_code != 3'h0))
        begin
            sys_div = sys_div >> 1; // RQ11
        end
        ref16_div = src_ext ? `RCG_REF32_DIV : `RCG_REF16_DIV; // RQ17
        ref32_div = src_ext ? 11'h001 : `RCG_REF32_DIV; // RQ17
        unique case (radio_clock_divider_sel)
            rcg_pkg::RCG_RDIV2: radio_div = 11'h002;
            rcg_pkg::RCG_RDIV4: radio_div = 11'h004;
            default:            radio_div = 11'h001;
        endcase
        reg_div = regulator_div4 ? 11'h004 : 11'h002;
    end

    rcg_clock_div #(.RESET_DIV(`RCG_SYS_DIV_RESET)) u_sys_div // RQ13
    (
        .core_clk (core_clk),
        .rst      (rst),
        .tick_in  (1'b1),
        .divisor  (sys_div),
        .tick_out (system_clock_en)
    );

    // Serial ports, random generator and flash share this reference
    rcg_clock_div #(.RESET_DIV(`RCG_REF16_DIV)) u_ref16_div // RQ18
    (
        .core_clk (core_clk),
        .rst      (rst),
        .tick_in  (1'b1),
        .divisor  (ref16_div),
        .tick_out (ref16_clock_en)
    );

    rcg_clock_div #(.RESET_DIV(`RCG_REF32_DIV)) u_ref32_div
    (
        .core_clk (core_clk),
        .rst      (rst),
        .tick_in  (1'b1),
        .divisor  (ref32_div),
        .tick_out (ref32_clock_en)
    );

    rcg_clock_div #(.RESET_DIV(`RCG_REF16_DIV)) u_conv_div // RQ22
    (
        .core_clk (core_clk),
        .rst      (rst),
        .tick_in  (1'b1),
        .divisor  (ref16_div),
        .tick_out (converter_clock_en)
    );

    // Counting converter ticks keeps the regulator clock in step with it
    rcg_clock_div #(.RESET_DIV(11'h002)) u_reg_div // RQ22
    (
        .core_clk (core_clk),
        .rst      (rst),
        .tick_in  (converter_clock_en),
        .divisor  (reg_div),
        .tick_out (regulator_clock_en)
    );

    rcg_clock_div #(.RESET_DIV(11'h002)) u_pka_div // RQ20
    (
        .core_clk (core_clk),
        .rst      (rst),
        .tick_in  (system_clock_en),
        .divisor  (11'h002),
        .tick_out (pka_clock_en)
    );

    rcg_clock_div #(.RESET_DIV(11'h001)) u_radio_div // RQ21
    (
        .core_clk (core_clk),
        .rst      (rst),
        .tick_in  (system_clock_en),
        .divisor  (radio_div),
        .tick_out (radio_bus_clock_en)
    );

    rcg_clock_div #(.RESET_DIV(`RCG_SLOW_HALF_DIV)) u_slow_div // RQ12
    (
        .core_clk (core_clk),
        .rst      (rst),
        .tick_in  (system_clock_en),
        .divisor  (`RCG_SLOW_HALF_DIV),
        .tick_out (slow_half_tick)
    );

    always_comb
    begin
        next_slow_sys_level = slow_half_tick ? !slow_sys_level : slow_sys_level;
        unique case (slow_source_sel)
            rcg_pkg::RCG_SLOW_RC:     next_slow_clock = sync_out[`RCG_SYNC_SLOW_RC];
            rcg_pkg::RCG_SLOW_OSC:    next_slow_clock = sync_out[`RCG_SYNC_SLOW_OSC];
            rcg_pkg::RCG_SLOW_SYSDIV: next_slow_clock = slow_sys_level;
            rcg_pkg::RCG_SLOW_PMU:    next_slow_clock = sync_out[`RCG_SYNC_PMU];
        endcase
        // Audio mode keeps its bit rate when the system clock is retuned
        if (spi_audio_mode)
        begin
            next_spi_en = spi_audio_ref32 ? ref32_clock_en : ref16_clock_en; // RQ19
        end
        else
        begin
            next_spi_en = system_clock_en; // RQ19
        end
        next_src_active = fast_source_sel; // RQ11
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            slow_sys_level     <= 1'b0;
            slow_clock         <= 1'b0;
            spi_bit_clock_en   <= 1'b0;
            timer_kernel_en    <= 1'b0;
            fast_source_active <= 2'h0;
        end
        else
        begin
            slow_sys_level     <= next_slow_sys_level;
            slow_clock         <= next_slow_clock;
            spi_bit_clock_en   <= next_spi_en;
            timer_kernel_en    <= 1'b1; // RQ16
            fast_source_active <= next_src_active;
        end
    end

    // Checks
    logic [`RCG_CNT_W-1:0] pad_len;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pad_len <= '0;
        end
        else
        begin
            pad_len <= external_reset_pad_n_oe ? pad_len + 12'(pad_len != '1) : '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_wdg_reset: assert property (watchdog_reset |=> !system_reset_n) // RQ1
        else $error("watchdog did not reset system");
    a_sw_request: assert property (reset_request_bit |=> !system_reset_n ##1 !system_reset_n) // RQ9
        else $error("reset request bit ignored");
    a_core_a_taken: assert property (core_a && !debugger_connected |=> !system_reset_n) // RQ8
        else $error("lock-up reset not taken");
    a_core_a_masked: assert property (rst_state == rcg_pkg::RCG_RST_IDLE && core_a
        && debugger_connected && !watchdog_reset && !reset_request_bit && !por_active
        |=> !external_reset_pad_n_oe) // RQ8
        else $error("lock-up reset taken with debugger");
    a_pad_driven: assert property (internal_req |=> external_reset_pad_n_oe
        && !external_reset_pad_n_out) // RQ2
        else $error("internal reset not on pad");
    a_min_pulse: assert property ($fell(external_reset_pad_n_oe)
        |-> pad_len >= `RCG_CNT_W'(`RCG_RST_MIN_CYC) && !system_reset_n) // RQ3
        else $error("reset pulse shorter than minimum");
    a_pad_external: assert property (pad_low_ext |=> !system_reset_n) // RQ4
        else $error("external pad low without system reset");
    a_por_hold: assert property (por_active |=> !por_reset_n && !retained_reset_n
        && !system_reset_n) // RQ6
        else $error("power-on reset not held");
    a_deepstop_exit: assert property (deepstop_exit && !por_active
        |=> !switched_core_reset_n && retained_reset_n) // RQ10
        else $error("deep-stop exit reset wrong domain");
    a_ref16_rate: assert property (ref16_clock_en && !$past(src_ext)
        |=> !ref16_clock_en [*3] ##1 ref16_clock_en) // RQ17
        else $error("16 MHz reference period wrong");

    c_internal_stretch: cover property ($fell(external_reset_pad_n_oe));
    c_external_pad: cover property (pad_low_ext ##1 !system_reset_n);
    c_slow_sysdiv: cover property (slow_source_sel == rcg_pkg::RCG_SLOW_SYSDIV
        && $rose(slow_clock));

endmodule

`default_nettype wire

// ---- rcg_board_pad.sv ----
`timescale 1ns/1ps
`default_nettype none

// Board reset line: open drain with a pull-up, so a released line reads high
module rcg_board_pad
(
    input  wire logic dev_oe,
    input  wire logic dev_out,
    input  wire logic board_pull,
    output var  logic pad_n
);
    always_comb
    begin
        pad_n = 1'b1;
        if (dev_oe)
        begin
            pad_n = dev_out;
        end
        if (board_pull)
        begin
            pad_n = 1'b0;
        end
    end
endmodule

`default_nettype wire

// ---- rcg_reset_clock_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module rcg_reset_clock_tb;
    logic       core_clk, rst, power_on_reset_n, supply_ok, regulator_ok, shutdown_exit;
    logic       watchdog_reset, core_a, debugger_connected, reset_request_bit, deepstop_exit;
    logic       external_reset_pad_n_in, external_reset_pad_n_out, external_reset_pad_n_oe;
    logic       system_reset_n, por_reset_n, retained_reset_n, switched_core_reset_n;
    logic [1:0] fast_source_sel, slow_source_sel, radio_clock_divider_sel, fast_source_active;
    logic [2:0] sys_freq_sel;
    logic       regulator_div4, spi_audio_mode, spi_audio_ref32, board_pull, sw;
    logic       internal_slow_rc, external_slow_osc, pmu_slow_clock, slow_clock;
    logic       system_clock_en, timer_kernel_en, ref16_clock_en, ref32_clock_en;
    logic       spi_bit_clock_en, pka_clock_en, radio_bus_clock_en;
    logic       converter_clock_en, regulator_clock_en;
    int         fail_count, cmp_count, cycles, lo, oe, ret, swc, g, n, f;
    wire  logic [7:0] ens = {spi_bit_clock_en, regulator_clock_en, converter_clock_en,
                             ref32_clock_en, ref16_clock_en, pka_clock_en,
                             radio_bus_clock_en, system_clock_en};
    // src frq rdiv div4 audio ref32 | gaps: sys radio pka ref16 ref32 conv reg spi
    int rows [11][14] = '{
        '{0, 2, 2, 0, 0, 0, 4, 16, 8, 4, 2, 4, 8, 4},
        '{0, 2, 1, 1, 1, 1, 4, 8, 8, 4, 2, 4, 16, 2},
        '{1, 1, 0, 0, 1, 0, 2, 2, 4, 4, 2, 4, 8, 4},
        '{0, 3, 2, 1, 0, 0, 8, 32, 16, 4, 2, 4, 16, 8},
        '{0, 4, 0, 0, 0, 0, 16, 16, 32, 4, 2, 4, 8, 16},
        '{0, 5, 1, 0, 0, 0, 32, 64, 64, 4, 2, 4, 8, 32},
        '{0, 6, 3, 0, 0, 0, 64, 64, 128, 4, 2, 4, 8, 64},
        '{0, 7, 0, 0, 0, 0, 64, 64, 128, 4, 2, 4, 8, 64},
        '{2, 0, 1, 0, 1, 1, 1, 2, 2, 2, 1, 2, 4, 1},
        '{2, 2, 2, 1, 1, 0, 2, 8, 4, 2, 1, 2, 8, 2},
        '{2, 6, 0, 0, 0, 0, 32, 32, 64, 2, 1, 2, 4, 32}};

    rcg_reset_clock DUT (.core_clk, .rst, .power_on_reset_n, .supply_ok, .regulator_ok,
        .shutdown_exit, .watchdog_reset, .core_a, .debugger_connected, .reset_request_bit,
        .deepstop_exit, .external_reset_pad_n_in, .external_reset_pad_n_out,
        .external_reset_pad_n_oe, .system_reset_n, .por_reset_n, .retained_reset_n,
        .switched_core_reset_n, .fast_source_sel, .sys_freq_sel, .slow_source_sel,
        .radio_clock_divider_sel, .regulator_div4, .spi_audio_mode, .spi_audio_ref32,
        .internal_slow_rc, .external_slow_osc, .pmu_slow_clock, .fast_source_active,
        .system_clock_en, .timer_kernel_en, .ref16_clock_en, .ref32_clock_en,
        .spi_bit_clock_en, .pka_clock_en, .radio_bus_clock_en, .converter_clock_en,
        .regulator_clock_en, .slow_clock);

    rcg_board_pad board (.dev_oe(external_reset_pad_n_oe), .dev_out(external_reset_pad_n_out),
        .board_pull, .pad_n(external_reset_pad_n_in));

    task automatic report_and_stop();
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_num(input int got, input int lo_l, input int hi_l);
        cmp_count++;
        if (got < lo_l || got > hi_l)
        begin
            fail_count++;
            $display("Error t=%0t count %0d outside %0d..%0d", $time, got, lo_l, hi_l);
        end
    endtask

    task automatic chk_bit(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error t=%0t value %b expected %b", $time, got, exp);
        end
    endtask

    task automatic quiet();
        {watchdog_reset, reset_request_bit, core_a, shutdown_exit} = 4'h0;
        {debugger_connected, deepstop_exit, board_pull} = 3'h0;
        {power_on_reset_n, supply_ok, regulator_ok} = 3'h7;
    endtask

    // Releases every request after hold cycles and tallies reset outputs
    task automatic watch(input int cyc, input int hold);
        lo = 0;
        oe = 0;
        ret = 0;
        swc = 0;
        for (int i = 0; i < cyc; i++)
        begin
            @(negedge core_clk);
            if (i == hold - 1)
                quiet();
            lo += int'(system_reset_n === 1'b0);
            oe += int'(external_reset_pad_n_oe === 1'b1 && external_reset_pad_n_out === 1'b0);
            ret += int'(retained_reset_n === 1'b0) + 2 * int'(por_reset_n === 1'b0);
            swc += int'(switched_core_reset_n === 1'b0);
        end
    endtask

    task automatic gap(input int s, output int gg);
        gg = 0;
        while (ens[s] !== 1'b1 && gg < 600)
        begin
            @(negedge core_clk);
            gg++;
        end
        gg = 0;
        do
        begin
            @(negedge core_clk);
            gg++;
        end
        while (ens[s] !== 1'b1 && gg < 600);
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 100000)
        begin
            fail_count++;
            report_and_stop();
        end
    end

    initial
    begin
        rst = 1'b1;
        quiet();
        {fast_source_sel, sys_freq_sel, slow_source_sel, radio_clock_divider_sel} = 9'h000;
        {regulator_div4, spi_audio_mode, spi_audio_ref32} = 3'h0;
        {internal_slow_rc, external_slow_osc, pmu_slow_clock} = 3'h0;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        // Divider leaves reset at /4 even though /1 is already selected
        f = 0;
        n = 0;
        while (system_reset_n !== 1'b1 && n < 3000)
        begin
            @(negedge core_clk);
            n++;
            if (f == 0 && system_clock_en === 1'b1)
                f = n;
        end
        chk_num(f, 3, 5);
        chk_num(n, 2500, 2600);
        foreach (rows[r])
        begin
            @(negedge core_clk);
            fast_source_sel = 2'(rows[r][0]);
            sys_freq_sel = 3'(rows[r][1]);
            radio_clock_divider_sel = 2'(rows[r][2]);
            {regulator_div4, spi_audio_mode, spi_audio_ref32} = 3'(rows[r][3] * 4 + rows[r][4] * 2 + rows[r][5]);
            repeat (600) @(negedge core_clk);
            for (int s = 0; s < 8; s++)
            begin
                gap(s, g);
                chk_num(g, rows[r][6 + s], rows[r][6 + s]);
            end
            chk_bit(fast_source_active, fast_source_sel);
            chk_bit({1'b0, timer_kernel_en}, 2'h1);
        end
        for (int s = 0; s < 8; s++)
        begin
            @(negedge core_clk);
            debugger_connected = (s == 7);
            case (s)
                0: watchdog_reset = 1'b1;
                1: reset_request_bit = 1'b1;
                2, 7: core_a = 1'b1;
                3: shutdown_exit = 1'b1;
                4: power_on_reset_n = 1'b0;
                5: supply_ok = 1'b0;
                default: regulator_ok = 1'b0;
            endcase
            watch(2700, 1);
            chk_num(lo, (s == 7) ? 0 : 2500, (s == 7) ? 0 : 2510);
            chk_num(oe, (s == 7) ? 0 : 2500, (s == 7) ? 0 : 2510);
            chk_num(ret, (s >= 3 && s <= 6) ? 3 : 0, (s >= 3 && s <= 6) ? 3 : 0);
        end
        @(negedge core_clk);
        board_pull = 1'b1;
        watch(100, 50);
        chk_num(lo, 50, 50);
        chk_num(oe, 0, 0);
        deepstop_exit = 1'b1;
        watch(100, 10);
        chk_num(swc, 10, 10);
        chk_num(lo + ret, 0, 0);
        for (int s = 0; s < 4; s++)
        begin
            for (int v = 0; v < 2 && s != 2; v++)
            begin
                @(negedge core_clk);
                slow_source_sel = 2'(s);
                f = (s == 0) ? 4 : ((s == 1) ? 2 : 1);
                {internal_slow_rc, external_slow_osc, pmu_slow_clock} = 3'(v ? f : ~f);
                repeat (6) @(negedge core_clk);
                chk_bit({1'b0, slow_clock}, 2'(v));
            end
        end
        // A period in progress must finish at the old length
        fast_source_sel = 2'h0;
        sys_freq_sel = 3'h6;
        repeat (300) @(negedge core_clk);
        n = 0;
        while (system_clock_en !== 1'b1 && n < 200)
        begin
            @(negedge core_clk);
            n++;
        end
        sys_freq_sel = 3'h0;
        gap(0, g);
        chk_num(g, 64, 64);
        slow_source_sel = 2'h2;
        for (int k = 0; k < 3; k++)
        begin
            sw = slow_clock;
            n = 0;
            while (slow_clock === sw && n < 2100)
            begin
                @(negedge core_clk);
                n++;
            end
        end
        chk_num(n, 1024, 1024);
        report_and_stop();
    end
endmodule

`default_nettype wire
